/* rtl/ocfp_format.sv */
/*
 Output clock and frame pulse format block. Holds the 16-bit selection
 register on a documented write port and drives two clocks and two pulses.
 Assumes sel_wr/sel_wdata come from the switch's own register decoder.
*/
`timescale 1ns/1ps
module ocfp_format
    import ocfp_pkg::*;
(
    input  wire logic                 core_clk,             // 100 MHz core clock
    input  wire logic                 rst_n,                // async reset, low
    input  wire logic                 clk_en,               // freeze when low
    input  wire logic                 sel_wr,               // write strobe
    input  wire logic [SEL_WIDTH-1:0] sel_wdata,            // write data
    output logic      [SEL_WIDTH-1:0] sel_rdata,            // register readback
    output logic                      frame_boundary,       // frame tick
    output logic                      clock_out_zero,       // output clock zero
    output logic                      clock_out_one,        // output clock one
    output logic                      frame_pulse_out_zero, // frame pulse zero
    output logic                      frame_pulse_out_one   // frame pulse one
);
    logic [SEL_WIDTH-1:0]   sel_q, sel_d;
    logic [FRAME_WIDTH-1:0] frm_q, frm_d;
    logic                   tick_q, tick_d;

    always_comb begin
        sel_d = sel_q;
        if (sel_wr) begin
            sel_d = sel_wdata;
        end
        frm_d  = (frm_q == FRAME_LAST) ? '0 : frm_q + 10'h001;
        tick_d = (frm_q == FRAME_LAST);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_q  <= SEL_RESET;
            frm_q  <= '0;
            tick_q <= 1'b0;
        end else if (clk_en) begin
            sel_q  <= sel_d;
            frm_q  <= frm_d;
            tick_q <= tick_d;
        end
    end

    assign sel_rdata      = sel_q;
    assign frame_boundary = tick_q & clk_en;

    ocfp_lane u_lane0 (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .clk_en     (clk_en),
        .half_count (CK0_HALF),
        .frame_tick (frame_boundary),
        .edge_sel   (sel_q[CK0_EDGE_BIT]),
        .fp_pol     (sel_q[FP0_POL_BIT]),
        .fp_pos     (sel_q[FP0_POS_BIT]),
        .clk_out    (clock_out_zero),
        .fp_out     (frame_pulse_out_zero)
    );

    ocfp_lane u_lane1 (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .clk_en     (clk_en),
        .half_count (CK1_HALF),
        .frame_tick (frame_boundary),
        .edge_sel   (sel_q[CK1_EDGE_BIT]),
        .fp_pol     (sel_q[FP1_POL_BIT]),
        .fp_pos     (sel_q[FP1_POS_BIT]),
        .clk_out    (clock_out_one),
        .fp_out     (frame_pulse_out_one)
    );

    property p_clk0_edge;
        @(posedge core_clk) disable iff (!rst_n)
        (frame_boundary && clk_en) |=> (clock_out_zero == sel_q[CK0_EDGE_BIT]);
    endproperty
    a_clk0_edge: assert property (p_clk0_edge) else $error("clock zero edge wrong");

    property p_clk1_edge;
        @(posedge core_clk) disable iff (!rst_n)
        (frame_boundary && clk_en) |=> (clock_out_one == sel_q[CK1_EDGE_BIT]);
    endproperty
    a_clk1_edge: assert property (p_clk1_edge) else $error("clock one edge wrong");

    property p_fp1_start;
        @(posedge core_clk) disable iff (!rst_n)
        (frame_boundary && clk_en && sel_q[FP1_POS_BIT] && !sel_wr)
        |=> (frame_pulse_out_one == sel_q[FP1_POL_BIT]);
    endproperty
    a_fp1_start: assert property (p_fp1_start) else $error("pulse one not at boundary");

    property p_fp0_start;
        @(posedge core_clk) disable iff (!rst_n)
        (frame_boundary && clk_en && sel_q[FP0_POS_BIT] && !sel_wr)
        |=> (frame_pulse_out_zero == sel_q[FP0_POL_BIT]);
    endproperty
    a_fp0_start: assert property (p_fp0_start) else $error("pulse zero not at boundary");

    property p_fp0_idle;
        @(posedge core_clk) disable iff (!rst_n)
        (frame_boundary && clk_en && !sel_wr)
        |=> ##3 (frame_pulse_out_zero == !sel_q[FP0_POL_BIT]) || !clk_en || $past(sel_wr);
    endproperty
    a_fp0_idle: assert property (p_fp0_idle) else $error("pulse zero stuck");

    property p_fp1_idle;
        @(posedge core_clk) disable iff (!rst_n)
        (frame_boundary && clk_en && !sel_wr)
        |=> ##5 (frame_pulse_out_one == !sel_q[FP1_POL_BIT]) || !clk_en || $past(sel_wr);
    endproperty
    a_fp1_idle: assert property (p_fp1_idle) else $error("pulse one stuck");

    property p_tick_period;
        @(posedge core_clk) disable iff (!rst_n)
        $rose(tick_q) |=> !tick_q;
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("tick too long");

    property p_wr_store;
        @(posedge core_clk) disable iff (!rst_n)
        (sel_wr && clk_en) |=> (sel_rdata == $past(sel_wdata));
    endproperty
    a_wr_store: assert property (p_wr_store) else $error("register write lost");

    // straddle: pulse already active in the boundary cycle itself
    property p_fp0_straddle;
        @(posedge core_clk) disable iff (!rst_n)
        (frame_boundary && !sel_q[FP0_POS_BIT] && !sel_wr && !$past(sel_wr)
            && !$past(sel_wr, 2) && !$past(sel_wr, 3))
        |-> (frame_pulse_out_zero == sel_q[FP0_POL_BIT]);
    endproperty
    a_fp0_straddle: assert property (p_fp0_straddle) else $error("pulse zero not early");

    property p_fp1_straddle;
        @(posedge core_clk) disable iff (!rst_n)
        (frame_boundary && !sel_q[FP1_POS_BIT] && !sel_wr && !$past(sel_wr)
            && !$past(sel_wr, 2) && !$past(sel_wr, 3))
        |-> (frame_pulse_out_one == sel_q[FP1_POL_BIT]);
    endproperty
    a_fp1_straddle: assert property (p_fp1_straddle) else $error("pulse one not early");

    property p_freeze;
        @(posedge core_clk) disable iff (!rst_n)
        !clk_en |=> ($stable(clock_out_zero) && $stable(clock_out_one)
            && $stable(frame_pulse_out_zero) && $stable(frame_pulse_out_one)
            && $stable(sel_rdata));
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");

    property p_ck0_toggle;
        @(posedge core_clk) disable iff (!rst_n)
        (clk_en && !frame_boundary && !sel_wr && !$past(sel_wr))
        |=> (clock_out_zero != $past(clock_out_zero));
    endproperty
    a_ck0_toggle: assert property (p_ck0_toggle) else $error("clock zero not toggling");

    // a half period of clock one is two cycles, so a change is followed by a hold
    property p_ck1_hold;
        @(posedge core_clk) disable iff (!rst_n)
        (clk_en && !frame_boundary && !sel_wr && !$past(sel_wr) && !$past(sel_wr, 2)
            && $changed(clock_out_one))
        |=> $stable(clock_out_one);
    endproperty
    a_ck1_hold: assert property (p_ck1_hold) else $error("clock one half period short");

    property p_frozen_write;
        @(posedge core_clk) disable iff (!rst_n)
        (sel_wr && !clk_en) |=> $stable(sel_rdata);
    endproperty
    a_frozen_write: assert property (p_frozen_write) else $error("frozen write landed");

    property p_boundary_single;
        @(posedge core_clk) disable iff (!rst_n)
        frame_boundary |=> !frame_boundary;
    endproperty
    a_boundary_single: assert property (p_boundary_single) else $error("boundary repeated");

    property p_fp0_width;
        @(posedge core_clk) disable iff (!rst_n)
        (frame_boundary && sel_q[FP0_POS_BIT] && !sel_wr) ##1 (clk_en && !sel_wr)
        |=> (frame_pulse_out_zero == !sel_q[FP0_POL_BIT]);
    endproperty
    a_fp0_width: assert property (p_fp0_width) else $error("pulse zero too long");

    property p_fp1_width;
        @(posedge core_clk) disable iff (!rst_n)
        (frame_boundary && sel_q[FP1_POS_BIT] && !sel_wr) ##1 (clk_en && !sel_wr)
        |=> (frame_pulse_out_one == sel_q[FP1_POL_BIT]);
    endproperty
    a_fp1_width: assert property (p_fp1_width) else $error("pulse one too short");

    property p_ck1_second;
        @(posedge core_clk) disable iff (!rst_n)
        (frame_boundary && !sel_wr) ##1 (clk_en && !sel_wr)
        |=> (clock_out_one == sel_q[CK1_EDGE_BIT]);
    endproperty
    a_ck1_second: assert property (p_ck1_second) else $error("clock one phase lost");

    property p_ck0_second;
        @(posedge core_clk) disable iff (!rst_n)
        (frame_boundary && !sel_wr) ##1 (clk_en && !sel_wr)
        |=> (clock_out_zero != sel_q[CK0_EDGE_BIT]);
    endproperty
    a_ck0_second: assert property (p_ck0_second) else $error("clock zero phase lost");
endmodule : ocfp_format

/* pkg/ocfp_pkg.sv */
/*
 Constants for the output clock and frame pulse format block: register layout,
 reset value, timing-base dividers. Assumes a 100 MHz core_clk.
*/
// What this block does
// - position bit 0 clear: frame pulse zero straddles the frame boundary.
// - position bit 3 set: frame pulse one starts exactly at frame boundary.
// - bit 1 clear gives active-low pulse zero; set gives active-high.
// - bit 2 clear: clock zero falling edge at boundary; set: rising edge.
// - bit 5 clear: clock one falling edge at boundary; set: rising edge.
package ocfp_pkg;
    localparam int          SEL_WIDTH      = 16;
    localparam logic [15:0] SEL_RESET      = 16'h0000;
    localparam int          FP0_POS_BIT    = 0;
    localparam int          FP0_POL_BIT    = 1;
    localparam int          CK0_EDGE_BIT   = 2;
    localparam int          FP1_POS_BIT    = 3;
    localparam int          FP1_POL_BIT    = 4;
    localparam int          CK1_EDGE_BIT   = 5;
    localparam int          USED_BITS      = 6;
    // half period of each output clock in core_clk cycles
    localparam int          HALF_WIDTH     = 4;
    localparam logic [3:0]  CK0_HALF       = 4'h1;
    localparam logic [3:0]  CK1_HALF       = 4'h2;
    // core_clk cycles per frame (frame counter width and last count)
    localparam int          FRAME_WIDTH    = 10;
    localparam logic [9:0]  FRAME_LAST     = 10'h3ff;
endpackage : ocfp_pkg

/* rtl/ocfp_lane.sv */
/*
 One output lane: clock edge alignment and a frame pulse shaped by polarity
 and position. Assumes a one-cycle frame_tick from the parent.
*/
`timescale 1ns/1ps
module ocfp_lane
    import ocfp_pkg::*;
(
    input  wire logic                  core_clk,   // core clock
    input  wire logic                  rst_n,      // async reset, low
    input  wire logic                  clk_en,     // freeze when low
    input  wire logic [HALF_WIDTH-1:0] half_count, // half period length
    input  wire logic                  frame_tick, // frame boundary pulse
    input  wire logic                  edge_sel,   // 1 rising at boundary
    input  wire logic                  fp_pol,     // 1 active high
    input  wire logic                  fp_pos,     // 1 start at boundary
    output logic                       clk_out,    // output clock
    output logic                       fp_out      // output frame pulse
);
    logic [HALF_WIDTH-1:0] cnt_q, cnt_d;
    logic                  phase_q, phase_d;
    logic                  pend_q, pend_d;
    logic [FRAME_WIDTH-1:0] pos_q, pos_d;
    logic [FRAME_WIDTH-1:0] pre_point;
    logic                  act_q, act_d;
    logic                  clk_q, clk_d;
    logic                  fp_q, fp_d;
    logic                  half_done;

    assign half_done = (cnt_q == half_count - 4'h1);
    // frame length is fixed, so the next boundary can be foreseen
    assign pre_point = FRAME_LAST - {{(FRAME_WIDTH-HALF_WIDTH){1'b0}}, half_count};

    always_comb begin
        cnt_d   = half_done ? '0 : cnt_q + 4'h1;
        phase_d = half_done ? ~phase_q : phase_q;
        pos_d   = pos_q + 10'h001;
        pend_d  = pend_q;
        act_d   = act_q;
        if (frame_tick) begin
            cnt_d   = '0;
            phase_d = 1'b1;
            pos_d   = '0;
            // straddle: pulse already asserted one half period before
            act_d   = fp_pos ? 1'b1 : act_q;
            pend_d  = 1'b1;
        end else if (half_done && pend_q) begin
            act_d  = 1'b0;
            pend_d = 1'b0;
        end else if (!fp_pos && (pos_q == pre_point)) begin
            act_d = 1'b1;
        end
        // clock phase 1 after boundary: rising when set, falling when clear
        clk_d = edge_sel ? phase_d : ~phase_d;
        fp_d  = fp_pol ? act_d : ~act_d;
    end

    assign clk_out = clk_q;
    assign fp_out  = fp_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q   <= '0;
            phase_q <= 1'b0;
            pend_q  <= 1'b0;
            pos_q   <= '0;
            act_q   <= 1'b0;
            clk_q   <= 1'b1;
            fp_q    <= 1'b1;
        end else if (clk_en) begin
            cnt_q   <= cnt_d;
            phase_q <= phase_d;
            pend_q  <= pend_d;
            pos_q   <= pos_d;
            act_q   <= act_d;
            clk_q   <= clk_d;
            fp_q    <= fp_d;
        end
    end
endmodule : ocfp_lane

/* sim/ocfp_sink.sv */
/*
 Downstream TDM device model: snapshots clocks and pulses just after a frame
 boundary. Assumes one core_clk domain shared with the switch.
*/
`timescale 1ns/1ps
module ocfp_sink (
    input  wire logic       core_clk,  // core clock
    input  wire logic       rst_n,     // async reset, low
    input  wire logic       boundary,  // frame tick from switch
    input  wire logic       ck0,       // clock zero
    input  wire logic       ck1,       // clock one
    input  wire logic       fp0,       // frame pulse zero
    input  wire logic       fp1,       // frame pulse one
    output logic [3:0]      snap,      // {ck1, ck0, fp0, fp1} after boundary
    output logic [7:0]      frames     // boundaries seen
);
    logic seen_q;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) seen_q <= 1'b0;
        else        seen_q <= boundary;
    end
    // sampled mid-cycle so registered outputs have settled
    always @(negedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            snap   <= 4'h0;
            frames <= 8'h00;
        end else if (seen_q) begin
            snap   <= {ck1, ck0, fp0, fp1};
            frames <= frames + 8'h01;
        end
    end
endmodule : ocfp_sink

/* sim/output_clock_frame_pulse_format_bench.sv */
/*
 Self-checking bench for the output clock and frame pulse format block.
 Assumes the sink model and a 100 MHz core_clk.
*/
`timescale 1ns/1ps
module output_clock_frame_pulse_format_bench;
    import ocfp_pkg::*;
    logic                 core_clk, rst_n, clk_en, sel_wr, fb, c0, c1, f0, f1;
    logic [SEL_WIDTH-1:0] sel_wdata, sel_rdata;
    logic [3:0]           snap;
    logic [7:0]           frames;
    int                   err_count, tests_run, cycles;
    logic [15:0]          cfg [5] = '{16'h0000, 16'h003f, 16'h0009, 16'h0036, 16'ha524};

    ocfp_format ocfp_format_i (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
        .sel_wr(sel_wr), .sel_wdata(sel_wdata), .sel_rdata(sel_rdata), .frame_boundary(fb),
        .clock_out_zero(c0), .clock_out_one(c1), .frame_pulse_out_zero(f0),
        .frame_pulse_out_one(f1));
    ocfp_sink ocfp_sink_i (.core_clk(core_clk), .rst_n(rst_n), .boundary(fb), .ck0(c0),
        .ck1(c1), .fp0(f0), .fp1(f1), .snap(snap), .frames(frames));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop

    // just after the boundary both pulse modes are active: level is the polarity bit
    function automatic logic [15:0] expect_snap(input logic [15:0] w);
        return {12'h000, w[5], w[2], w[1], w[4]};
    endfunction : expect_snap

    // boundary cycle: only a straddling pulse is already active
    task automatic check_early(input logic [15:0] w);
        do @(negedge core_clk); while (fb !== 1'b1 && cycles < 20000);
        check({14'h0000, f0, f1}, {14'h0000, w[0] ? !w[1] : w[1], w[3] ? !w[4] : w[4]});
    endtask : check_early

    task automatic write_sel(input logic [15:0] w, input logic en);
        @(negedge core_clk);
        sel_wr    = 1'b1;
        sel_wdata = w;
        clk_en    = en;
        @(negedge core_clk);
        sel_wr = 1'b0;
        clk_en = 1'b1;
        @(negedge core_clk);
    endtask : write_sel

    task automatic wait_frame;
        logic [7:0] start;
        start = frames;
        for (int i = 0; i < 2100 && frames == start; i++) @(posedge core_clk);
        @(posedge core_clk);
    endtask : wait_frame

    task automatic reset_defaults;
        check(sel_rdata, SEL_RESET);
        check_early(SEL_RESET);
        wait_frame();
        check({12'h000, snap}, expect_snap(16'h0000));
    endtask : reset_defaults

    task automatic format_table;
        foreach (cfg[i]) begin
            write_sel(cfg[i], 1'b1);
            check(sel_rdata, cfg[i]);
            check_early(cfg[i]);
            wait_frame();
            check({12'h000, snap}, expect_snap(cfg[i]));
        end
    endtask : format_table

    task automatic frozen_write;
        write_sel(16'h0012, 1'b0);
        check(sel_rdata, cfg[4]);
    endtask : frozen_write

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            report_and_stop();
        end
    end

    initial begin
        err_count = 0;
        tests_run = 0;
        cycles    = 0;
        rst_n     = 1'b0;
        clk_en    = 1'b1;
        sel_wr    = 1'b0;
        sel_wdata = 16'h0000;
        repeat (2) @(negedge core_clk);
        rst_n = 1'b1;
        reset_defaults();
        format_table();
        frozen_write();
        report_and_stop();
    end
endmodule : output_clock_frame_pulse_format_bench
